// ===== adspc_pkg.sv
/*
 * Shared constants and types for the audio processor control register bank.
 * Assumes a serial port front end that has already assembled whole words.
 */
`default_nettype none
package adspc_pkg;
   // Serial port word addresses.
   localparam logic [10:0] ADDR_CTRL1 = 11'h100;
   localparam logic [10:0] ADDR_CTRL2 = 11'h101;
   localparam logic [10:0] ADDR_SAFE_BASE = 11'h112;
   localparam int SAFE_COUNT = 5;
   // Register widths, writable masks and reset values.
   localparam int CTRL1_W = 14;
   localparam int CTRL2_W = 10;
   localparam logic [13:0] CTRL1_MASK = 14'h36ff;
   localparam logic [9:0] CTRL2_MASK = 10'h3f7;
   localparam logic [13:0] CTRL1_RESET = 14'h0000;
   localparam logic [9:0] CTRL2_RESET = 10'h000;
   // First control register fields.
   localparam int C1_WLEN_LO = 0;
   localparam int C1_FMT_LO = 2;
   localparam int C1_DEEMPH_LO = 4;
   localparam int C1_PDOWN = 6;
   localparam int C1_MUTE = 7;
   localparam int C1_SAFE_GO = 9;
   localparam int C1_HALT = 10;
   localparam int C1_CAPOUT_LO = 12;
   // Second control register fields.
   localparam int C2_CKOUT_LO = 0;
   localparam int C2_CKRATE = 2;
   localparam int C2_CKSEL_LO = 4;
   localparam int C2_SRCSEL_LO = 6;
   localparam int C2_SOUT_EN = 8;
   localparam int C2_RAMP_SLOW = 9;
   // Read-back bit positions.
   localparam int RB_SAFE_DONE = 0;
   localparam int RB_HALT_DONE = 1;
   // Gain scale: unity is 4096, full scale 8192.
   localparam logic [13:0] GAIN_UNITY = 14'h1000;
   localparam logic [13:0] GAIN_FULL = 14'h2000;
   localparam int RAMP_FAST_FRAMES = 1024;
   localparam int RAMP_SLOW_FRAMES = 8192;
   localparam logic [13:0] STEP_FAST = 14'(8192 / RAMP_FAST_FRAMES);
   localparam logic [13:0] STEP_SLOW = 14'(8192 / RAMP_SLOW_FRAMES);
   // Clock out codes.
   localparam logic [1:0] CKOUT_OFF = 2'h0;
   localparam logic [1:0] CKOUT_CORE = 2'h1;
   localparam logic [1:0] CKOUT_HALF = 2'h2;
   localparam logic [1:0] CKOUT_THRU = 2'h3;

   typedef struct packed {
      logic [1:0] capture_out_mode;
      logic [1:0] deemphasis;
      logic [1:0] serial_format;
      logic [1:0] word_length;
   } adspc_format_s;

   typedef struct packed {
      logic [1:0] clock_out_mode;
      logic doubler_on;
      logic [1:0] clock_in_select;
      logic [1:0] serial_source_select;
   } adspc_clock_s;

   typedef struct packed {
      logic data;
      logic frame_clk;
      logic bit_clk;
   } adspc_serial_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [21:0] data;
   } adspc_pair_s;

   typedef enum logic [2:0] {
      SL_IDLE = 3'b001,
      SL_WAIT = 3'b010,
      SL_COPY = 3'b100
   } adspc_safe_e;
endpackage : adspc_pkg
`default_nettype wire

// ===== adspc_regs.sv
/*
 * Control register bank of a three channel audio processor: mode bits, mute
 * and halt ramps, safeload copy, clock and serial source selection.
 * Assumes the serial port front end delivers one-cycle write and read strobes
 * with a word address, and that frame_tick_in pulses once per audio frame.
 */
`default_nettype none
`timescale 1ns/1ps
module adspc_regs
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic reg_read_done_in,
   input wire logic [10:0] reg_addr_in,
   input wire logic [29:0] reg_wdata_in,
   output logic [1:0] reg_rdata_out,
   input wire logic frame_tick_in,
   input wire logic [13:0] volume_level_in,
   input wire adspc_pkg::adspc_serial_s serial_source_a_in,
   input wire adspc_pkg::adspc_serial_s serial_source_b_in,
   input wire adspc_pkg::adspc_serial_s serial_source_c_in,
   output adspc_pkg::adspc_serial_s serial_selected_out,
   output adspc_pkg::adspc_serial_s serial_pins_out,
   output logic [2:0] serial_pins_oe_out,
   output adspc_pkg::adspc_format_s format_out,
   output adspc_pkg::adspc_clock_s clock_ctrl_out,
   output logic master_clock_half_out,
   output logic core_clock_enable_out,
   output logic [13:0] gain_out,
   output logic param_we_out,
   output adspc_pkg::adspc_pair_s param_pair_out
);
   logic rst_meta_n, rst_n;
   logic [13:0] ctrl1, next_ctrl1;
   logic [9:0] ctrl2, next_ctrl2;
   logic [13:0] gain, next_gain;
   logic halt_done, next_halt_done;
   logic safe_done, next_safe_done;
   logic [1:0] rdata, next_rdata;
   logic half_clk;
   logic [4:0] pending, next_pending;
   adspc_pkg::adspc_safe_e sl_state, next_sl_state;
   adspc_pkg::adspc_pair_s safe_mem [adspc_pkg::SAFE_COUNT];
   adspc_pkg::adspc_pair_s pair_q, next_pair_q;
   logic we_q, next_we_q;
   logic wr_c1, wr_c2;
   logic [4:0] safe_hit, pick;
   logic [2:0] pick_idx;
   logic [13:0] target, step;
   logic [10:0] safe_off;

   // Reset release through two flops; only the pin resets anything.
   // pin-only reset.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_meta_n <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_meta_n <= 1'b1;
         rst_n <= rst_meta_n;
      end
   end

   // Address decode of the two control registers and five safeload slots.
   // control register addresses.
   assign wr_c1 = reg_write_in && (reg_addr_in == adspc_pkg::ADDR_CTRL1);
   assign wr_c2 = reg_write_in && (reg_addr_in == adspc_pkg::ADDR_CTRL2);
   assign safe_off = reg_addr_in - adspc_pkg::ADDR_SAFE_BASE;

   // One hot hit vector for the safeload slots.
   always_comb
   begin
      safe_hit = 5'h00;
      for (int i = 0; i < adspc_pkg::SAFE_COUNT; i++)
         if (reg_write_in && (safe_off == 11'(i)))
            safe_hit[i] = 1'b1;
   end

   // Register writes; unused positions are masked so they are stored as zero.
   // unused bits masked.
   always_comb
   begin
      next_ctrl1 = ctrl1;
      next_ctrl2 = ctrl2;
      if (wr_c1)
         next_ctrl1 = reg_wdata_in[13:0] & adspc_pkg::CTRL1_MASK;
      if (wr_c2)
         next_ctrl2 = reg_wdata_in[9:0] & adspc_pkg::CTRL2_MASK;
   end

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl1 <= adspc_pkg::CTRL1_RESET;
         ctrl2 <= adspc_pkg::CTRL2_RESET;
      end
      else
      begin
         ctrl1 <= next_ctrl1;
         ctrl2 <= next_ctrl2;
      end
   end

   // Mode fields for the serial input, de-emphasis and capture output paths.
   // word length field.
   assign format_out.word_length = ctrl1[adspc_pkg::C1_WLEN_LO +: 2];
   assign format_out.serial_format = ctrl1[adspc_pkg::C1_FMT_LO +: 2];
   assign format_out.deemphasis = ctrl1[adspc_pkg::C1_DEEMPH_LO +: 2];
   assign format_out.capture_out_mode = ctrl1[adspc_pkg::C1_CAPOUT_LO +: 2];

   // Clock tree controls; the code 11 input select is passed on as unused.
   // clock out mode.
   assign clock_ctrl_out.clock_out_mode = ctrl2[adspc_pkg::C2_CKOUT_LO +: 2];
   assign clock_ctrl_out.doubler_on = ctrl2[adspc_pkg::C2_CKRATE];
   assign clock_ctrl_out.clock_in_select = ctrl2[adspc_pkg::C2_CKSEL_LO +: 2];
   assign clock_ctrl_out.serial_source_select = ctrl2[adspc_pkg::C2_SRCSEL_LO +: 2];

   // Halved core clock, high after reset so it runs inverted to a half-rate input.
   // halved and inverted.
   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
         half_clk <= 1'b1;
      else
         half_clk <= (ctrl2[adspc_pkg::C2_CKOUT_LO +: 2] == adspc_pkg::CKOUT_HALF) ?
                     !half_clk : 1'b1;
   end
   assign master_clock_half_out = half_clk;

   // Serial source mux; the pins only drive once enabled.
   // source multiplexer.
   always_comb
   begin
      unique case (ctrl2[adspc_pkg::C2_SRCSEL_LO +: 2])
         2'h0: serial_selected_out = serial_source_a_in;
         2'h1: serial_selected_out = serial_source_b_in;
         2'h2: serial_selected_out = serial_source_c_in;
         default: serial_selected_out = '0;
      endcase
   end

   assign serial_pins_out = ctrl2[adspc_pkg::C2_SOUT_EN] ? serial_selected_out : '0;
   assign serial_pins_oe_out = {3{ctrl2[adspc_pkg::C2_SOUT_EN]}};

   // Gain ramp: target zero under mute or halt, else the volume setting clamped to full scale.
   // ramp speed.
   assign step = ctrl2[adspc_pkg::C2_RAMP_SLOW] ? adspc_pkg::STEP_SLOW : adspc_pkg::STEP_FAST;
   assign target = (ctrl1[adspc_pkg::C1_MUTE] || ctrl1[adspc_pkg::C1_HALT]) ? 14'h0000 :
                   ((volume_level_in > adspc_pkg::GAIN_FULL) ? adspc_pkg::GAIN_FULL :
                    volume_level_in);

   always_comb
   begin
      next_gain = gain;
      next_halt_done = ctrl1[adspc_pkg::C1_HALT] && (gain == 14'h0000);
      if (frame_tick_in)
      begin
         if (gain > target)
            next_gain = ((gain - target) > step) ? gain - step : target;
         else if (gain < target)
            next_gain = ((target - gain) > step) ? gain + step : target;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         gain <= adspc_pkg::GAIN_UNITY;
         halt_done <= 1'b0;
      end
      else
      begin
         gain <= next_gain;
         halt_done <= next_halt_done;
      end
   end
   assign gain_out = gain;

   // Core clock gating: power-down or finished halt stop it, no state is lost.
   // clock gate only.
   assign core_clock_enable_out = !ctrl1[adspc_pkg::C1_PDOWN] && !halt_done;

   // Safeload slot storage, written by the serial port.
   always_ff @(posedge clock_in)
   begin
      for (int i = 0; i < adspc_pkg::SAFE_COUNT; i++)
         if (safe_hit[i])
            safe_mem[i] <= reg_wdata_in;
   end

   // Lowest pending slot goes first.
   always_comb
   begin
      pick = 5'h00;
      pick_idx = 3'h0;
      for (int i = adspc_pkg::SAFE_COUNT - 1; i >= 0; i--)
      begin
         if (pending[i])
         begin
            pick = 5'(1) << i;
            pick_idx = 3'(i);
         end
      end
   end

   // Safeload sequencer: waits for a frame boundary, then copies one pair a cycle.
   // copy written slots only.
   always_comb
   begin
      next_sl_state = sl_state;
      next_we_q = 1'b0;
      next_pair_q = pair_q;
      next_pending = pending;
      next_safe_done = safe_done && !(reg_read_done_in && rdata[adspc_pkg::RB_SAFE_DONE]);
      unique case (sl_state)
         adspc_pkg::SL_IDLE:
         begin
            if (wr_c1 && reg_wdata_in[adspc_pkg::C1_SAFE_GO])
               next_sl_state = adspc_pkg::SL_WAIT;
         end
         adspc_pkg::SL_WAIT:
         begin
            if (frame_tick_in)
               next_sl_state = adspc_pkg::SL_COPY;
         end
         adspc_pkg::SL_COPY:
         begin
            if (pending == 5'h00)
            begin
               next_sl_state = adspc_pkg::SL_IDLE;
               next_safe_done = 1'b1;
            end
            else
            begin
               next_we_q = 1'b1;
               next_pair_q = safe_mem[pick_idx];
               next_pending = pending & ~pick;
            end
         end
         default: next_sl_state = adspc_pkg::SL_IDLE;
      endcase
      next_pending = next_pending | safe_hit;
   end

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sl_state <= adspc_pkg::SL_IDLE;
         pending <= 5'h00;
         safe_done <= 1'b0;
         we_q <= 1'b0;
         pair_q <= '0;
      end
      else
      begin
         sl_state <= next_sl_state;
         pending <= next_pending;
         safe_done <= next_safe_done;
         we_q <= next_we_q;
         pair_q <= next_pair_q;
      end
   end
   assign param_we_out = we_q;
   assign param_pair_out = pair_q;

   // Read-back word, latched at every read strobe; zero unless the first register is read.
   always_comb
   begin
      next_rdata = rdata;
      if (reg_read_in)
         next_rdata = (reg_addr_in == adspc_pkg::ADDR_CTRL1) ? {halt_done, safe_done} : 2'h0;
   end

   always_ff @(posedge clock_in or negedge rst_n)
   begin
      if (!rst_n)
         rdata <= 2'h0;
      else
         rdata <= next_rdata;
   end
   assign reg_rdata_out = rdata;

   // Checks on the design's own behaviour.
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rst_n);

   sequence s_go;
      wr_c1 && reg_wdata_in[adspc_pkg::C1_SAFE_GO] && sl_state == adspc_pkg::SL_IDLE;
   endsequence
   sequence s_copy_end;
      sl_state == adspc_pkg::SL_COPY && pending == 5'h00 && safe_hit == 5'h00;
   endsequence

   chk_mask_unused: assert property (ctrl1[8] == 1'b0 && ctrl1[11] == 1'b0 && ctrl2[3] == 1'b0)
      else $error("Unused control bit stored.");
   chk_mute_step: assert property (frame_tick_in && ctrl1[adspc_pkg::C1_MUTE]
         && !ctrl2[adspc_pkg::C2_RAMP_SLOW] && gain >= 14'h0008 |=> gain == $past(gain) - 14'h0008)
      else $error("Mute ramp step wrong.");
   chk_unmute_rise: assert property (frame_tick_in && !ctrl1[adspc_pkg::C1_MUTE]
         && !ctrl1[adspc_pkg::C1_HALT] && gain < target |=> gain > $past(gain))
      else $error("Gain did not rise after unmute.");
   chk_slow_step: assert property (frame_tick_in && ctrl2[adspc_pkg::C2_RAMP_SLOW] && gain != target
         |=> (gain == $past(gain) + 14'h0001) || (gain == $past(gain) - 14'h0001))
      else $error("Slow ramp step wrong.");
   chk_halt_done: assert property (ctrl1[adspc_pkg::C1_HALT] && gain == 14'h0000
         |=> halt_done && !core_clock_enable_out)
      else $error("Shutdown not reported.");
   chk_halt_ramp: assert property (halt_done |-> gain == 14'h0000)
      else $error("Shutdown before ramp end.");
   chk_pdown_gate: assert property (ctrl1[adspc_pkg::C1_PDOWN] |-> !core_clock_enable_out)
      else $error("Core clock runs in power-down.");
   chk_safe_done: assert property (s_copy_end |=> safe_done)
      else $error("Safeload done not set.");
   chk_safe_wait: assert property (s_go |=> sl_state == adspc_pkg::SL_WAIT && !param_we_out)
      else $error("Safeload did not wait for frame.");
   chk_pins_off: assert property (!ctrl2[adspc_pkg::C2_SOUT_EN] |-> serial_pins_oe_out == 3'h0)
      else $error("Serial pins driven while disabled.");
   chk_half_clk: assert property (clock_ctrl_out.clock_out_mode == adspc_pkg::CKOUT_HALF
         ##1 clock_ctrl_out.clock_out_mode == adspc_pkg::CKOUT_HALF
         |-> half_clk != $past(half_clk))
      else $error("Halved clock not toggling.");
endmodule : adspc_regs
`default_nettype wire

// ===== adspc_host_model.sv
/*
 * Host model that issues word writes and reads to the control register bank.
 * Assumes the bank samples strobes on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
module adspc_host_model
(
   input wire logic clock_in,
   input wire logic [1:0] rdata_in,
   output logic write_out,
   output logic read_out,
   output logic read_done_out,
   output logic [10:0] addr_out,
   output logic [29:0] wdata_out
);
   // The bus starts idle.
   initial
   begin
      write_out = 1'b0;
      read_out = 1'b0;
      read_done_out = 1'b0;
      addr_out = 11'h000;
      wdata_out = 30'h00000000;
   end

   // One write strobe; released lines show the inverse so stale values never pass.
   task automatic write_reg(input logic [10:0] addr, input logic [29:0] data);
      @(posedge clock_in);
      write_out <= 1'b1;
      addr_out <= addr;
      wdata_out <= data;
      @(posedge clock_in);
      write_out <= 1'b0;
      addr_out <= ~addr;
      wdata_out <= ~data;
   endtask : write_reg

   // Read strobe, capture the registered answer, then end the serial read.
   task automatic read_reg(input logic [10:0] addr, output logic [1:0] data);
      @(posedge clock_in);
      read_out <= 1'b1;
      addr_out <= addr;
      @(posedge clock_in);
      read_out <= 1'b0;
      addr_out <= ~addr;
      #1;
      data = rdata_in;
      @(posedge clock_in);
      read_done_out <= 1'b1;
      @(posedge clock_in);
      read_done_out <= 1'b0;
   endtask : read_reg

   task automatic write_ctrl1(input logic [13:0] value);
      write_reg(adspc_pkg::ADDR_CTRL1, 30'(value));
   endtask : write_ctrl1

   task automatic write_ctrl2(input logic [9:0] value);
      write_reg(adspc_pkg::ADDR_CTRL2, 30'(value));
   endtask : write_ctrl2
endmodule : adspc_host_model
`default_nettype wire

// ===== tb_top.sv
/*
 * Self-checking bench for the control register bank, driven through the host model.
 * Assumes a 20 MHz clock and frame ticks generated here.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clock_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic reg_write, reg_read, reg_read_done;
   logic [10:0] reg_addr;
   logic [29:0] reg_wdata;
   logic [1:0] reg_rdata;
   logic frame_tick = 1'b0;
   logic [13:0] volume_level = 14'h1000;
   adspc_pkg::adspc_serial_s src_a = 3'h1;
   adspc_pkg::adspc_serial_s src_b = 3'h2;
   adspc_pkg::adspc_serial_s src_c = 3'h4;
   adspc_pkg::adspc_serial_s sel, pins;
   logic [2:0] pins_oe;
   adspc_pkg::adspc_format_s fmt;
   adspc_pkg::adspc_clock_s cctl;
   logic half_clk, core_en, param_we;
   logic [13:0] gain;
   adspc_pkg::adspc_pair_s pair;
   adspc_pkg::adspc_pair_s copied[$];
   logic [1:0] rb;
   logic h0, h1;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;

   adspc_host_model u_host (.clock_in(clock_in), .rdata_in(reg_rdata), .write_out(reg_write),
      .read_out(reg_read), .read_done_out(reg_read_done), .addr_out(reg_addr),
      .wdata_out(reg_wdata));

   adspc_regs DUT (.clock_in(clock_in), .arst_n_in(arst_n_in), .reg_write_in(reg_write),
      .reg_read_in(reg_read), .reg_read_done_in(reg_read_done), .reg_addr_in(reg_addr),
      .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata), .frame_tick_in(frame_tick),
      .volume_level_in(volume_level), .serial_source_a_in(src_a),
      .serial_source_b_in(src_b), .serial_source_c_in(src_c),
      .serial_selected_out(sel), .serial_pins_out(pins), .serial_pins_oe_out(pins_oe),
      .format_out(fmt), .clock_ctrl_out(cctl), .master_clock_half_out(half_clk),
      .core_clock_enable_out(core_en), .gain_out(gain), .param_we_out(param_we),
      .param_pair_out(pair));

   // Clock generation.
   always #25 clock_in = ~clock_in;

   // Collect every copied parameter pair.
   always @(posedge clock_in)
   begin
      if (param_we === 1'b1)
         copied.push_back(pair);
   end

   // Cut a hang short.
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         failures++;
         tally_and_finish();
      end
   end

   // Compare one observed value against its expectation.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Issue frame ticks, then let the bank settle.
   task automatic ticks(input int n);
      repeat (n)
      begin
         @(posedge clock_in);
         frame_tick <= 1'b1;
         @(posedge clock_in);
         frame_tick <= 1'b0;
      end
      repeat (5) @(posedge clock_in);
      #1;
   endtask : ticks

   // Print the verdict and stop.
   task automatic tally_and_finish();
      if (failures == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (6) @(posedge clock_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clock_in);
      #1;
      check("clock_ctrl", cctl, 32'h0);
      check("oe", pins_oe, 32'h0);
      check("gain", gain, 32'h1000);
      // field codes, with unused bits set.
      for (int i = 0; i < 4; i++)
      begin
         u_host.write_ctrl1(14'(i * 32'h1015 + 32'h0900));
         #1;
         check("format", fmt, 32'(i * 32'h55));
         check("core_en", core_en, 32'h1);
      end
      u_host.write_ctrl1(14'h0045);
      #1;
      check("pdown_en", core_en, 32'h0);
      check("pdown_fmt", fmt, 32'h05);
      u_host.write_ctrl1(14'h0000);
      #1;
      check("pup_en", core_en, 32'h1);
      for (int c = 0; c < 4; c++)
      begin
         u_host.write_ctrl2(10'(c + (c % 2) * 4));
         @(posedge clock_in);
         #1;
         h0 = half_clk;
         @(posedge clock_in);
         #1;
         h1 = half_clk;
         check("ckout", cctl, 32'(c * 32 + (c % 2) * 16));
         check("half", 32'(h0 ^ h1) + 32'(h1 & (c != 2)), (c == 2) ? 32'h1 : 32'h1);
      end
      u_host.write_ctrl2(10'h000);
      u_host.write_reg(11'h112, {8'h12, 22'h2abcd});
      u_host.write_reg(11'h114, {8'h34, 22'h01234});
      u_host.write_ctrl1(14'h0200);
      ticks(1);
      check("copies", copied.size(), 32'h2);
      check("slot0", copied[0], {2'h0, 8'h12, 22'h2abcd});
      check("slot1", copied[1], {2'h0, 8'h34, 22'h01234});
      u_host.read_reg(adspc_pkg::ADDR_CTRL1, rb);
      check("safe_done", rb[0], 32'h1);
      u_host.read_reg(adspc_pkg::ADDR_CTRL1, rb);
      check("safe_clr", rb[0], 32'h0);
      u_host.write_ctrl1(14'h0200);
      ticks(1);
      check("no_stale", copied.size(), 32'h2);
      u_host.write_ctrl1(14'h0080);
      ticks(256);
      check("mute_half", gain, 32'h800);
      ticks(255);
      check("mute_511", gain, 32'h8);
      ticks(1);
      check("mute_end", gain, 32'h0);
      // Return to a lower volume, then to a clamped high one, then back to unity.
      @(posedge clock_in);
      volume_level <= 14'h0800;
      u_host.write_ctrl1(14'h0000);
      ticks(256);
      check("unmute_part", gain, 32'h800);
      @(posedge clock_in);
      volume_level <= 14'h3fff;
      ticks(768);
      check("clamp", gain, 32'h2000);
      @(posedge clock_in);
      volume_level <= 14'h1000;
      ticks(512);
      check("unmute", gain, 32'h1000);
      u_host.write_ctrl2(10'h200);
      u_host.write_ctrl1(14'h0080);
      ticks(16);
      check("slow", gain, 32'h0ff0);
      u_host.write_ctrl1(14'h0000);
      ticks(16);
      check("slow_up", gain, 32'h1000);
      u_host.write_ctrl2(10'h000);
      // halt ramps down then reports shutdown.
      u_host.write_ctrl1(14'h0400);
      ticks(511);
      u_host.read_reg(adspc_pkg::ADDR_CTRL1, rb);
      check("halt_early", rb[1], 32'h0);
      ticks(1);
      u_host.read_reg(adspc_pkg::ADDR_CTRL1, rb);
      check("halt_done", rb[1], 32'h1);
      check("halt_en", core_en, 32'h0);
      // sources change only while the core is shut down.
      for (int s = 0; s < 3; s++)
      begin
         u_host.write_ctrl2(10'(32'h108 + s * 32'h50));
         #1;
         check("src_sel", sel, 32'(1 << s));
         check("src_pins", pins, 32'(1 << s));
         check("src_oe", pins_oe, 32'h7);
         check("src_ctrl", cctl, 32'(s * 5));
         // Invert every source pin so the selected one must follow it.
         @(posedge clock_in);
         src_a <= ~src_a;
         src_b <= ~src_b;
         src_c <= ~src_c;
         @(posedge clock_in);
         #1;
         check("src_flip", pins, 32'(7 ^ (1 << s)));
         @(posedge clock_in);
         src_a <= ~src_a;
         src_b <= ~src_b;
         src_c <= ~src_c;
      end
      u_host.write_ctrl2(10'h000);
      #1;
      check("oe_off", pins_oe, 32'h0);
      // unmapped places have no effect and read as zero.
      u_host.write_reg(11'h17f, 30'h3fffffff);
      #1;
      check("unmapped_w", cctl, 32'h0);
      u_host.read_reg(11'h1ff, rb);
      check("unmapped_r", rb, 32'h0);
      @(posedge clock_in);
      arst_n_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      #1;
      check("rst_en", core_en, 32'h1);
      check("rst_gain", gain, 32'h1000);
      check("rst_rb", reg_rdata, 32'h0);
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
